// ### mmdec_pkg.sv
`default_nettype none
package mmdec_pkg;
   // internal data space
   localparam logic [7:0] UPPER_BASE = 8'h80;
   localparam logic [7:0] BANK_END = 8'h1f;
   localparam logic [7:0] BIT_BASE = 8'h20;
   localparam logic [7:0] BIT_END = 8'h2f;
   localparam int REG_PER_BANK = 8;
   localparam logic [7:0] PAGE_SEL_ADDR = 8'h84;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   // external data space
   localparam int XRAM_AW = 12;
   localparam logic [15:0] XRAM_SIZE = 16'h1000;
   // program flash
   localparam int SECTOR_AW = 9;
   localparam logic [16:0] RSV_LO = 17'h0fe00;
   localparam logic [16:0] RSV_HI = 17'h0ffff;
   localparam logic [16:0] SCRATCH_LO = 17'h10000;
   localparam logic [16:0] SCRATCH_HI = 17'h1007f;
   localparam logic [16:0] MAIN_SIZE_64K = 17'h10000;
   typedef enum logic [1:0] {
      MMDEC_XMAP_ONCHIP,
      MMDEC_XMAP_OFFCHIP,
      MMDEC_XMAP_SPLIT,
      MMDEC_XMAP_RSVD
   } mmdec_xmap_e;
   typedef enum logic [1:0] {
      MMDEC_TGT_NONE,
      MMDEC_TGT_RAM,
      MMDEC_TGT_SPECIAL
   } mmdec_tgt_e;
endpackage
`default_nettype wire

// ### mmdec_xbus.sv
`timescale 1ns/100ps
`default_nettype none
// off-chip data routing and bus-port address/data presentation
module mmdec_xbus (
   input wire logic [15:0] xaddr,
   input wire logic [7:0] xwdata,
   input wire logic [1:0] xmap,
   input wire logic mux_mode,
   output logic onchip,
   output logic [11:0] onchip_addr,
   output logic [15:0] addr_lines,
   output logic [7:0] ad_lines
);
   // choose target for each mapping choice
   always_comb begin
      case (mmdec_pkg::mmdec_xmap_e'(xmap))
         mmdec_pkg::MMDEC_XMAP_ONCHIP: onchip = 1'b1; // [RQ7]
         mmdec_pkg::MMDEC_XMAP_OFFCHIP: onchip = 1'b0; // [RQ7]
         mmdec_pkg::MMDEC_XMAP_SPLIT: onchip = (xaddr < mmdec_pkg::XRAM_SIZE); // [RQ7]
         default: onchip = 1'b1;
      endcase
   end
   // block aliases on every 4 kB boundary by dropping high bits
   assign onchip_addr = xaddr[mmdec_pkg::XRAM_AW-1:0]; // [RQ6]
   // multiplexed: low address shares lines with data; otherwise separate
   always_comb begin
      if (mux_mode) begin // [RQ8]
         addr_lines = {xaddr[15:8], 8'h00};
         ad_lines = xaddr[7:0];
      end else begin
         addr_lines = xaddr;
         ad_lines = xwdata;
      end
   end
endmodule
`default_nettype wire

// ### mmdec_top.sv
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// [RQ1] Indirect accesses at 0x80-0xff reach upper ram; direct ones reach the special space.
// [RQ2] The special space is paged with up to 256 pages selected by the active page.
// [RQ3] The lower 128 bytes map to the same storage for direct and indirect access.
// [RQ4] The first 32 bytes form four banks of eight working registers.
// [RQ5] The 16 bytes after the banks are reachable as bytes and as single bits.
// [RQ6] When mapped on-chip, the 4 kB block aliases across the whole 64 kB data range.
// [RQ7] Off-chip data is mapped all on-chip, all off-chip, or split at 4 kB.
// [RQ8] The bus port drives address and data multiplexed or on separate lines.
// [RQ9] Flash is reprogrammed in 512-byte sectors with no external voltage.
// [RQ10] On 64 kB parts program addresses 0xfe00-0xffff are reserved from user code.
// [RQ11] An extra 128-byte sector sits at 0x10000-0x1007f apart from the main array.
// [RQ12] A writable page-select register applies its page to every direct special access.
module mmdec_top #(
   parameter logic [16:0] MAIN_SIZE = mmdec_pkg::MAIN_SIZE_64K
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   // internal data access
   input wire logic iacc_valid,
   input wire logic iacc_indirect,
   input wire logic iacc_bit,
   input wire logic iacc_write,
   input wire logic [7:0] iacc_addr,
   input wire logic [7:0] iacc_wdata,
   input wire logic [1:0] bank_sel,
   // external data access
   input wire logic xacc_valid,
   input wire logic xacc_write,
   input wire logic [15:0] xacc_addr,
   input wire logic [7:0] xacc_wdata,
   input wire logic [1:0] xmap,
   input wire logic mux_mode,
   // program flash access
   input wire logic pacc_valid,
   input wire logic pacc_erase,
   input wire logic [16:0] pacc_addr,
   // ram side
   output logic iram_en,
   output logic iram_we,
   output logic [7:0] iram_addr,
   output logic [7:0] iram_wdata,
   output logic [7:0] iram_bmask,
   output logic spec_en,
   output logic spec_we,
   output logic [7:0] spec_page,
   output logic [7:0] spec_addr,
   output logic [7:0] spec_wdata,
   output logic [7:0] page_q,
   output logic xram_en,
   output logic xram_we,
   output logic [11:0] xram_addr,
   output logic [7:0] xram_wdata,
   output logic port_en,
   output logic port_we,
   output logic port_ale,
   output logic [15:0] port_addr,
   output logic [7:0] port_ad,
   output logic [7:0] port_wdata,
   // flash side
   output logic fl_en,
   output logic fl_erase,
   output logic fl_scratch,
   output logic [16:0] fl_addr,
   output logic [16:0] fl_sector_base,
   output logic fl_fault
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic [1:0] rst_sync_q;
   logic rst_ok;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) rst_sync_q <= 2'b00;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_ok = rst_sync_q[1];

   // bit address 0x00-0x7f picks a byte in the 0x20-0x2f area
   function automatic logic [7:0] bit_byte(input logic [7:0] a);
      bit_byte = mmdec_pkg::BIT_BASE + {4'h0, a[6:3]};
   endfunction

   // inclusive range test, shared by the reserved and extra-sector decodes
   function automatic logic in_span(input logic [16:0] a, input logic [16:0] lo, input logic [16:0] hi);
      in_span = (a >= lo) && (a <= hi);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // internal data decode
   logic upper;
   logic to_special;
   logic [7:0] ram_a;
   // upper half starts where the dual mapping begins
   assign upper = (iacc_addr >= mmdec_pkg::UPPER_BASE);
   // upper half is dual mapped; lower half ignores the mode
   assign to_special = upper && !iacc_indirect; // [RQ1] [RQ3]
   always_comb begin
      if (iacc_bit && !upper) ram_a = bit_byte(iacc_addr); // [RQ5]
      // working registers sit at their plain address; the core folds the bank in
      else if (iacc_addr <= mmdec_pkg::BANK_END) ram_a = iacc_addr; // [RQ4]
      else ram_a = iacc_addr;
   end

   // page select lives in the special space itself, so it follows every page
   always_ff @(posedge sys_clk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) page_q <= mmdec_pkg::PAGE_RESET;
      else if (iacc_valid && iacc_write && to_special &&
               iacc_addr == mmdec_pkg::PAGE_SEL_ADDR)
         page_q <= iacc_wdata; // [RQ12] [RQ2]
   end

   // ram and special-space strobes, registered toward the arrays
   always_ff @(posedge sys_clk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) begin
         iram_en <= 1'b0;
         iram_we <= 1'b0;
         iram_addr <= 8'h00;
         iram_wdata <= 8'h00;
         iram_bmask <= 8'h00;
         spec_en <= 1'b0;
         spec_we <= 1'b0;
         spec_page <= 8'h00;
         spec_addr <= 8'h00;
         spec_wdata <= 8'h00;
      end else begin
         iram_en <= iacc_valid && !to_special; // [RQ1] [RQ3]
         iram_we <= iacc_valid && !to_special && iacc_write;
         iram_addr <= ram_a; // [RQ4] [RQ5]
         iram_wdata <= iacc_wdata;
         // whole byte unless one bit of the bit area is picked
         iram_bmask <= (iacc_bit && !upper) ? 8'h01 << iacc_addr[2:0] : 8'hff; // [RQ5]
         spec_en <= iacc_valid && to_special; // [RQ1]
         spec_we <= iacc_valid && to_special && iacc_write;
         spec_page <= page_q; // [RQ2] [RQ12]
         spec_addr <= iacc_addr;
         spec_wdata <= iacc_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // external data routing
   logic x_onchip;
   logic [11:0] x_loc;
   logic [15:0] x_lines;
   logic [7:0] x_ad;
   // routing is combinational in the child; every port output is flopped here
   mmdec_xbus u_xbus (
      .xaddr(xacc_addr),
      .xwdata(xacc_wdata),
      .xmap(xmap),
      .mux_mode(mux_mode),
      .onchip(x_onchip),
      .onchip_addr(x_loc),
      .addr_lines(x_lines),
      .ad_lines(x_ad)
   );
   always_ff @(posedge sys_clk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) begin
         xram_en <= 1'b0;
         xram_we <= 1'b0;
         xram_addr <= 12'h000;
         xram_wdata <= 8'h00;
         port_en <= 1'b0;
         port_we <= 1'b0;
         port_ale <= 1'b0;
         port_addr <= 16'h0000;
         port_ad <= 8'h00;
         port_wdata <= 8'h00;
      end else begin
         xram_en <= xacc_valid && x_onchip; // [RQ6] [RQ7]
         xram_we <= xacc_valid && x_onchip && xacc_write;
         xram_addr <= x_loc; // [RQ6]
         xram_wdata <= xacc_wdata;
         port_en <= xacc_valid && !x_onchip; // [RQ7]
         port_we <= xacc_valid && !x_onchip && xacc_write;
         // latch strobe only matters when the low lines are shared
         port_ale <= xacc_valid && !x_onchip && mux_mode; // [RQ8]
         port_addr <= x_lines; // [RQ8]
         port_ad <= x_ad;
         port_wdata <= xacc_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program flash decode; erase works on whole sectors from the core supply
   logic in_rsv;
   logic in_scr;
   logic in_main;
   logic fl_hit;
   logic [16:0] sect;
   assign in_rsv = (MAIN_SIZE == mmdec_pkg::MAIN_SIZE_64K) &&
                   in_span(pacc_addr, mmdec_pkg::RSV_LO, mmdec_pkg::RSV_HI); // [RQ10]
   assign in_scr = in_span(pacc_addr, mmdec_pkg::SCRATCH_LO, mmdec_pkg::SCRATCH_HI); // [RQ11]
   assign in_main = pacc_addr < MAIN_SIZE;
   // anything outside both arrays is refused just like the reserved region
   assign fl_hit = !in_rsv && (in_main || in_scr);
   // scratch sector is smaller than a main sector, so its base is its start
   assign sect = in_scr ? mmdec_pkg::SCRATCH_LO
                        : {pacc_addr[16:mmdec_pkg::SECTOR_AW], {mmdec_pkg::SECTOR_AW{1'b0}}};
   // the fault flag pulses for the refused cycle only; the core decides what follows
   always_ff @(posedge sys_clk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) begin
         fl_en <= 1'b0;
         fl_erase <= 1'b0;
         fl_scratch <= 1'b0;
         fl_addr <= 17'h00000;
         fl_sector_base <= 17'h00000;
         fl_fault <= 1'b0;
      end else begin
         fl_en <= pacc_valid && fl_hit; // [RQ10] [RQ11]
         fl_erase <= pacc_valid && pacc_erase && fl_hit; // [RQ9]
         fl_scratch <= pacc_valid && in_scr; // [RQ11]
         fl_addr <= pacc_addr;
         fl_sector_base <= sect; // [RQ9]
         fl_fault <= pacc_valid && !fl_hit; // [RQ10]
      end
   end
   // bank choice is already resolved into plain addresses, so it is only sunk here
   logic unused_ok;
   assign unused_ok = rst_ok ^ (^bank_sel);
endmodule
`default_nettype wire

// ### mmdec_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mmdec_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic iacc_valid,
   input wire logic iacc_indirect,
   input wire logic [7:0] iacc_addr,
   input wire logic iram_en,
   input wire logic spec_en,
   input wire logic [7:0] spec_page,
   input wire logic [7:0] page_q,
   input wire logic xacc_valid,
   input wire logic [15:0] xacc_addr,
   input wire logic [1:0] xmap,
   input wire logic xram_en,
   input wire logic [11:0] xram_addr,
   input wire logic port_en,
   input wire logic pacc_valid,
   input wire logic [16:0] pacc_addr,
   input wire logic fl_en,
   input wire logic fl_fault,
   input wire logic fl_scratch
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // direct request into the upper half, shared by the routing and page checks
   sequence s_dir_hi;
      iacc_valid && !iacc_indirect && iacc_addr[7];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_upper_ind: assert property (
      iacc_valid && iacc_indirect && iacc_addr[7] |=> iram_en && !spec_en)
      else $error("indirect upper access not sent to ram");
   chk_upper_dir: assert property (
      s_dir_hi |=> spec_en && !iram_en) else $error("direct upper access not special");
   chk_page_use: assert property (
      s_dir_hi |=> spec_page == $past(page_q)) else $error("special page not applied");
   chk_lower_same: assert property (
      iacc_valid && !iacc_addr[7] |=> iram_en && !spec_en) else $error("lower half not ram");
   chk_xram_alias: assert property (
      xacc_valid && xmap == 2'h0 |=> xram_en && xram_addr == $past(xacc_addr[11:0]))
      else $error("on-chip block does not alias");
   chk_split_high: assert property (
      xacc_valid && xmap == 2'h2 && xacc_addr[15:12] != 4'h0 |=> port_en && !xram_en)
      else $error("split high address not off chip");
   chk_rsvd_flash: assert property (
      pacc_valid && pacc_addr[16:9] == 8'h7f |=> fl_fault && !fl_en)
      else $error("reserved flash region reached");
   chk_scratch_sec: assert property (
      pacc_valid && pacc_addr[16:7] == 10'h200 |=> fl_en && fl_scratch && !fl_fault)
      else $error("extra sector not reached");
endmodule
bind mmdec_top mmdec_chk chk_i (.*);
`default_nettype wire

// ### mmdec_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module mmdec_core_model (
   input wire logic sys_clk,
   output logic iacc_valid,
   output logic iacc_indirect,
   output logic iacc_bit,
   output logic iacc_write,
   output logic [7:0] iacc_addr,
   output logic [7:0] iacc_wdata,
   output logic [1:0] bank_sel,
   output logic xacc_valid,
   output logic xacc_write,
   output logic [15:0] xacc_addr,
   output logic [7:0] xacc_wdata,
   output logic [1:0] xmap,
   output logic mux_mode,
   output logic pacc_valid,
   output logic pacc_erase,
   output logic [16:0] pacc_addr
);
   // idle core: every line defined from time zero
   initial begin
      {iacc_valid, iacc_indirect, iacc_bit, iacc_write, iacc_addr, iacc_wdata} = '0;
      {bank_sel, xacc_valid, xacc_write, xacc_addr, xacc_wdata, xmap, mux_mode} = '0;
      {pacc_valid, pacc_erase, pacc_addr} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // each request stands one cycle; the answer is settled when a task returns
   task automatic req_i(input logic ind, bt, wr, input logic [7:0] a, d);
      @(posedge sys_clk);
      #1 {iacc_valid, iacc_indirect, iacc_bit, iacc_write, iacc_addr, iacc_wdata} = {1'b1, ind, bt, wr, a, d};
      @(posedge sys_clk);
      #1 iacc_valid = 1'b0;
   endtask
   task automatic req_x(input logic [1:0] m, input logic mx, wr, input logic [15:0] a);
      @(posedge sys_clk);
      #1 {xacc_valid, xmap, mux_mode, xacc_write, xacc_addr, xacc_wdata} = {1'b1, m, mx, wr, a, 8'h77};
      @(posedge sys_clk);
      #1 xacc_valid = 1'b0;
   endtask
   task automatic req_p(input logic er, input logic [16:0] a);
      @(posedge sys_clk);
      #1 {pacc_valid, pacc_erase, pacc_addr} = {1'b1, er, a};
      @(posedge sys_clk);
      #1 pacc_valid = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### mmdec_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mmdec_top_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic iacc_valid, iacc_indirect, iacc_bit, iacc_write, xacc_valid, xacc_write;
   logic mux_mode, pacc_valid, pacc_erase, iram_en, iram_we, spec_en, spec_we;
   logic xram_en, xram_we, port_en, port_we, port_ale, fl_en, fl_erase, fl_scratch, fl_fault;
   logic [1:0] bank_sel, xmap;
   logic [7:0] iacc_addr, iacc_wdata, xacc_wdata, iram_addr, iram_wdata, iram_bmask;
   logic [7:0] spec_page, spec_addr, spec_wdata, page_q, xram_wdata, port_ad, port_wdata;
   logic [11:0] xram_addr;
   logic [15:0] xacc_addr, port_addr;
   logic [16:0] pacc_addr, fl_addr, fl_sector_base;
   int mismatches = 0;
   int n_compared = 0;
   mmdec_top uut (.*);
   mmdec_core_model core (.*);
   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_idata;
      core.req_i(1'b1, 1'b0, 1'b0, 8'h90, 8'h00);
      chk("ind_hi", {iram_en, spec_en, iram_addr}, {2'h2, 8'h90});
      core.req_i(1'b0, 1'b0, 1'b0, 8'h90, 8'h00);
      chk("dir_hi", {iram_en, spec_en, spec_addr}, {2'h1, 8'h90});
      core.req_i(1'b0, 1'b0, 1'b1, 8'h1f, 8'h3c);
      chk("bank", {iram_we, iram_addr, iram_wdata}, {1'b1, 8'h1f, 8'h3c});
      core.req_i(1'b1, 1'b0, 1'b0, 8'h1f, 8'h00);
      chk("lo_ind", {iram_en, spec_en, iram_addr}, {2'h2, 8'h1f});
      core.req_i(1'b0, 1'b1, 1'b0, 8'h0b, 8'h00);
      chk("bit", {iram_addr, iram_bmask}, {8'h21, 8'h08});
      core.req_i(1'b0, 1'b0, 1'b0, 8'h2f, 8'h00);
      chk("byte", {iram_addr, iram_bmask}, {8'h2f, 8'hff});
      $display("internal data test done");
   endtask
   // the last page value shows the full page range, not only small numbers
   task automatic t_page;
      logic [7:0] pg;
      for (int i = 0; i < 2; i++) begin
         pg = i[0] ? 8'hff : 8'h5a;
         core.req_i(1'b0, 1'b0, 1'b1, mmdec_pkg::PAGE_SEL_ADDR, pg);
         chk("page_q", page_q, pg);
         chk("spec_wr", {spec_en, spec_we, spec_wdata}, {2'h3, pg});
         core.req_i(1'b0, 1'b0, 1'b0, 8'hc0, 8'h00);
         chk("spec_page", {spec_en, spec_page}, {1'b1, pg});
      end
      $display("page test done");
   endtask
   task automatic t_xdata;
      core.req_x(2'h0, 1'b0, 1'b0, 16'hf123);
      chk("alias", {xram_en, port_en, xram_addr}, {2'h2, 12'h123});
      core.req_x(2'h2, 1'b0, 1'b1, 16'h0fff);
      chk("split_lo", {xram_en, port_en, xram_addr}, {2'h2, 12'hfff});
      chk("xram_wr", {xram_we, xram_wdata}, {1'b1, 8'h77});
      core.req_x(2'h3, 1'b0, 1'b0, 16'h2345);
      chk("map3", {xram_en, port_en, xram_addr}, {2'h2, 12'h345});
      core.req_x(2'h2, 1'b0, 1'b1, 16'h1000);
      chk("split_hi", {xram_en, port_en, port_addr}, {2'h1, 16'h1000});
      chk("sep_data", {port_ale, port_we, port_wdata}, {2'h1, 8'h77});
      chk("sep_ad", port_ad, 8'h77);
      core.req_x(2'h1, 1'b1, 1'b0, 16'habcd);
      chk("mux_ad", {xram_en, port_ale, port_ad}, {2'h1, 8'hcd});
      chk("mux_hi", port_addr, 16'hab00);
      $display("external data test done");
   endtask
   task automatic t_flash;
      core.req_p(1'b0, 17'h0fe00);
      chk("rsvd_lo", {fl_en, fl_fault}, 2'h1);
      core.req_p(1'b0, 17'h0ffff);
      chk("rsvd_hi", {fl_en, fl_fault}, 2'h1);
      core.req_p(1'b1, 17'h0fdff);
      chk("erase", {fl_en, fl_erase, fl_fault}, 3'h6);
      chk("sector", fl_sector_base, 17'h0fc00);
      chk("fl_addr", fl_addr, 17'h0fdff);
      core.req_p(1'b0, 17'h1007f);
      chk("scratch", {fl_en, fl_scratch, fl_sector_base}, {2'h3, 17'h10000});
      core.req_p(1'b0, 17'h10080);
      chk("beyond", {fl_en, fl_fault}, 2'h1);
      $display("flash test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence; the watchdog cuts a hang short
   initial begin
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("reset_idle", {iram_en, spec_en, xram_en, port_en, fl_en, fl_fault, page_q}, 14'h0);
      t_idata;
      t_page;
      t_xdata;
      t_flash;
      print_verdict;
   end
   initial begin
      #20000;
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
